// [eccs_pkg.sv]
/*
 * Package for the ECC statistics and error-injection block: register
 * offsets, field layout, reset values and carrier structs.
 * Assumes a 32-bit plain register port with byte addresses.
 */
package eccs_pkg;
    localparam int          CNT_W        = 8;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [11:0] OFF_INJ_PKT  = 12'h3a0;
    localparam logic [11:0] OFF_INJ_PCS  = 12'h3a4;
    localparam logic [11:0] OFF_MASK_TX  = 12'h3b0;
    localparam logic [11:0] OFF_MASK_RX  = 12'h3b4;
    localparam logic [11:0] OFF_MASK_PCS = 12'h3b8;
    localparam logic [11:0] OFF_XAUI_MBE = 12'h414;
    localparam logic [11:0] OFF_TOT_SBE  = 12'h418;
    localparam logic [11:0] OFF_TOT_MBE  = 12'h41c;
    localparam logic [11:0] OFF_TX_DROP  = 12'h420;
    localparam logic [11:0] OFF_RX_DROP  = 12'h424;
    localparam int          INJ_TX_BIT   = 0;
    localparam int          INJ_RX_BIT   = 1;
    localparam logic [7:0]  CNT_RESET    = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hff;
    localparam logic [31:0] REG_RESET    = 32'h0000_0000;
    localparam logic [1:0]  PCS_SPAN     = 2'h2;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } eccs_req_s;

    // Error reports from the three protected storages
    typedef struct packed {
        logic tx_sbe;
        logic tx_mbe;
        logic rx_sbe;
        logic rx_mbe;
        logic pcs_sbe;
        logic pcs_mbe;
        logic tx_drop;
        logic rx_drop;
    } eccs_err_s;
endpackage

// [eccs_top.sv]
/*
 * ECC statistics counters and error-injection control.
 * Assumes single-cycle register strobes on the core clock, error reports
 * from the FIFO ECC decoders on the same clock, and FIFO write strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module eccs_top
    import eccs_pkg::*;
#(
    parameter int PKT_W = 32,
    parameter int PCS_W = 32
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire eccs_pkg::eccs_req_s   req,
    output var  logic [31:0]           rdata,
    input  wire eccs_pkg::eccs_err_s   err,
    input  wire logic                  tx_wr,
    input  wire logic                  tx_sop,
    input  wire logic                  rx_wr,
    input  wire logic                  rx_sop,
    input  wire logic                  pcs_wr,
    output var  logic [PKT_W-1:0]      tx_flip,
    output var  logic [PKT_W-1:0]      rx_flip,
    output var  logic [PCS_W-1:0]      pcs_flip,
    output var  logic                  ecc_sbe,
    output var  logic                  ecc_mbe,
    output var  logic                  ecc_packet_dropped
);
    import eccs_pkg::*;

    // Each mask must fit one register word; wider masks would need
    // more offsets than the map reserves, so they are refused here
    if (PKT_W < 1 || PKT_W > DATA_W ||
        PCS_W < 1 || PCS_W > DATA_W) begin : g_bad_width
        $error("eccs_top: mask widths must be 1..32");
    end

    logic [PKT_W-1:0] mask_tx_reg;
    logic [PKT_W-1:0] mask_rx_reg;
    logic [PCS_W-1:0] mask_pcs_reg;
    logic [1:0]       packet_fifo_inject_ctrl;
    logic             pcs_fifo_inject_ctrl;
    logic [1:0]       pcs_left_reg;
    logic [CNT_W-1:0] cnt_reg [5];
    logic [4:0]       cnt_inc;
    logic [4:0]       cnt_rd;
    logic             tx_hit;
    logic             rx_hit;
    logic             pcs_hit;

    // Register map, every entry one word with unused bits reading zero:
    //   insertion arm for the packet FIFOs, bit 0 transmit, bit 1 receive
    //   insertion arm for the PCS FIFOs, bit 0
    //   transmit, receive and PCS masks, low bits of their own words
    //   PCS multi-bit count, total single-bit and multi-bit counts
    //   transmit and receive drop counts
    // Counter offsets ignore writes; software can only read them
    // to zero, so a stray write cannot hide a fault count.
    // Masks wider than one word are a known limitation.

    // Packet FIFOs corrupt only a packet start; PCS any write
    assign tx_hit  = packet_fifo_inject_ctrl[INJ_TX_BIT] && tx_wr && tx_sop;
    assign rx_hit  = packet_fifo_inject_ctrl[INJ_RX_BIT] && rx_wr && rx_sop;
    assign pcs_hit = pcs_fifo_inject_ctrl && pcs_wr;

    // A mask may be rewritten while armed; the flip uses the value
    // held in the cycle of the hit
    // Mask registers, software writes only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mask_tx_reg  <= '0;
            mask_rx_reg  <= '0;
            mask_pcs_reg <= '0;
        end else if (req.wr) begin
            if (req.addr == OFF_MASK_TX)
                mask_tx_reg <= req.wdata[PKT_W-1:0];
            if (req.addr == OFF_MASK_RX)
                mask_rx_reg <= req.wdata[PKT_W-1:0];
            if (req.addr == OFF_MASK_PCS)
                mask_pcs_reg <= req.wdata[PCS_W-1:0];
        end
    end

    // Packet insertion bits; a software write wins over the hardware
    // clear of the bit that was just used
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            packet_fifo_inject_ctrl <= 2'h0;
        end else begin
            if (req.wr && req.addr == OFF_INJ_PKT)
                packet_fifo_inject_ctrl <= req.wdata[1:0];
            else begin
                if (tx_hit)
                    packet_fifo_inject_ctrl[INJ_TX_BIT] <= 1'b0;
                if (rx_hit)
                    packet_fifo_inject_ctrl[INJ_RX_BIT] <= 1'b0;
            end
        end
    end

    // PCS insertion: stays armed over skipped writes, then covers
    // a span of two writes since columns straddle cycles
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pcs_fifo_inject_ctrl <= 1'b0;
            pcs_left_reg         <= 2'h0;
        end else begin
            if (req.wr && req.addr == OFF_INJ_PCS)
                pcs_fifo_inject_ctrl <= req.wdata[0];
            else if (pcs_hit)
                pcs_fifo_inject_ctrl <= 1'b0;
            if (pcs_hit)
                pcs_left_reg <= PCS_SPAN - 2'h1;
            else if (pcs_wr && pcs_left_reg != 2'h0)
                pcs_left_reg <= pcs_left_reg - 2'h1;
        end
    end

    // Registered so the FIFO sees a clean vector; the cost is that
    // the FIFO applies it one cycle after its write strobe
    // Flip vectors: masked bits only, registered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_flip  <= '0;
            rx_flip  <= '0;
            pcs_flip <= '0;
        end else begin
            tx_flip  <= tx_hit ? mask_tx_reg : '0;
            rx_flip  <= rx_hit ? mask_rx_reg : '0;
            pcs_flip <= (pcs_hit || (pcs_wr && pcs_left_reg != 2'h0))
                        ? mask_pcs_reg : '0;
        end
    end

    // Totals take one step per cycle, so coincident errors from
    // several storages count once
    // Counter increment sources
    always_comb begin
        cnt_inc[0] = err.pcs_mbe;
        cnt_inc[1] = err.tx_sbe | err.rx_sbe | err.pcs_sbe;
        cnt_inc[2] = err.tx_mbe | err.rx_mbe | err.pcs_mbe;
        cnt_inc[3] = err.tx_drop;
        cnt_inc[4] = err.rx_drop;
        cnt_rd[0]  = req.rd && req.addr == OFF_XAUI_MBE;
        cnt_rd[1]  = req.rd && req.addr == OFF_TOT_SBE;
        cnt_rd[2]  = req.rd && req.addr == OFF_TOT_MBE;
        cnt_rd[3]  = req.rd && req.addr == OFF_TX_DROP;
        cnt_rd[4]  = req.rd && req.addr == OFF_RX_DROP;
    end

    // Saturating clear-on-read counters; an event in the read cycle
    // is kept as a count of one rather than lost
    for (genvar i = 0; i < 5; i++) begin : g_cnt
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n)
                cnt_reg[i] <= CNT_RESET;
            else if (cnt_rd[i])
                cnt_reg[i] <= cnt_inc[i] ? 8'h01 : CNT_RESET;
            else if (cnt_inc[i] && cnt_reg[i] != CNT_MAX)
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
        end

        // Per-counter checks, one copy for each of the five counters
        a_cnt_sat: assert property (
            @(posedge clock) disable iff (!arst_n)
            (cnt_reg[i] == CNT_MAX && !cnt_rd[i]) |=> cnt_reg[i] == CNT_MAX)
            else $error("counter left saturation before a read");
        a_cnt_clear: assert property (
            @(posedge clock) disable iff (!arst_n)
            (cnt_rd[i] && !cnt_inc[i]) |=> cnt_reg[i] == CNT_RESET)
            else $error("counter not cleared by its read");
        a_cnt_idle: assert property (
            @(posedge clock) disable iff (!arst_n)
            (!cnt_inc[i] && !cnt_rd[i]) |=> $stable(cnt_reg[i]))
            else $error("counter moved without event or read");
    end

    // Counters clear on the read strobe edge, so the value returned
    // is the last one before the clear
    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= REG_RESET;
        end else if (req.rd) begin
            case (req.addr)
                OFF_MASK_TX:  rdata <= DATA_W'(mask_tx_reg);
                OFF_MASK_RX:  rdata <= DATA_W'(mask_rx_reg);
                OFF_MASK_PCS: rdata <= DATA_W'(mask_pcs_reg);
                OFF_INJ_PKT:  rdata <= {30'h0, packet_fifo_inject_ctrl};
                OFF_INJ_PCS:  rdata <= {31'h0, pcs_fifo_inject_ctrl};
                OFF_XAUI_MBE: rdata <= {24'h0, cnt_reg[0]};
                OFF_TOT_SBE:  rdata <= {24'h0, cnt_reg[1]};
                OFF_TOT_MBE:  rdata <= {24'h0, cnt_reg[2]};
                OFF_TX_DROP:  rdata <= {24'h0, cnt_reg[3]};
                OFF_RX_DROP:  rdata <= {24'h0, cnt_reg[4]};
                default:      rdata <= REG_RESET;
            endcase
        end else begin
            rdata <= REG_RESET;
        end
    end

    // Observation pulses; drops come from packet FIFOs only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ecc_sbe            <= 1'b0;
            ecc_mbe            <= 1'b0;
            ecc_packet_dropped <= 1'b0;
        end else begin
            ecc_sbe            <= cnt_inc[1];
            ecc_mbe            <= cnt_inc[2];
            ecc_packet_dropped <= err.tx_drop | err.rx_drop;
        end
    end

    // Counter steps, saturation and read behaviour
    a_sat_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_reg[2] == CNT_MAX && !cnt_rd[2]) |=> cnt_reg[2] == CNT_MAX)
        else $error("total fatal count left saturation");
    a_read_clears: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_rd[0] && !cnt_inc[0]) |=> cnt_reg[0] == 8'h00)
        else $error("read did not clear pcs count");
    a_read_value: assert property (
        @(posedge clock) disable iff (!arst_n)
        cnt_rd[1] |=> rdata == {24'h0, $past(cnt_reg[1])})
        else $error("read data wrong for corrected count");
    a_count_step: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_inc[3] && !cnt_rd[3] && cnt_reg[3] != CNT_MAX)
        |=> cnt_reg[3] == $past(cnt_reg[3]) + 8'h01)
        else $error("tx drop count did not step");
    a_rx_drop_step: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_inc[4] && !cnt_rd[4] && cnt_reg[4] != CNT_MAX)
        |=> cnt_reg[4] == $past(cnt_reg[4]) + 8'h01)
        else $error("rx drop count did not step");
    a_pcs_mbe_step: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_inc[0] && !cnt_rd[0] && cnt_reg[0] != CNT_MAX)
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 8'h01)
        else $error("pcs multi-bit count did not step");
    a_total_sbe: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_inc[1] && !cnt_rd[1] && cnt_reg[1] != CNT_MAX)
        |=> cnt_reg[1] == $past(cnt_reg[1]) + 8'h01)
        else $error("total single-bit count did not step");
    a_total_mbe: assert property (
        @(posedge clock) disable iff (!arst_n)
        (cnt_inc[2] && !cnt_rd[2] && cnt_reg[2] != CNT_MAX)
        |=> cnt_reg[2] == $past(cnt_reg[2]) + 8'h01)
        else $error("total multi-bit count did not step");

    // Injection timing, mask use and self-clearing arms
    a_tx_first: assert property (
        @(posedge clock) disable iff (!arst_n)
        (tx_wr && !tx_sop) |=> tx_flip == '0)
        else $error("tx corruption off packet start");
    a_rx_first: assert property (
        @(posedge clock) disable iff (!arst_n)
        (rx_wr && !rx_sop) |=> rx_flip == '0)
        else $error("rx corruption off packet start");
    a_tx_quiet: assert property (
        @(posedge clock) disable iff (!arst_n)
        !tx_hit |=> tx_flip == '0)
        else $error("tx corruption without armed start");
    a_rx_quiet: assert property (
        @(posedge clock) disable iff (!arst_n)
        !rx_hit |=> rx_flip == '0)
        else $error("rx corruption without armed start");
    a_tx_arm_keep: assert property (
        @(posedge clock) disable iff (!arst_n)
        (packet_fifo_inject_ctrl[INJ_TX_BIT] && !tx_hit && !req.wr)
        |=> packet_fifo_inject_ctrl[INJ_TX_BIT])
        else $error("tx arm lost before a packet start");
    a_rx_arm_keep: assert property (
        @(posedge clock) disable iff (!arst_n)
        (packet_fifo_inject_ctrl[INJ_RX_BIT] && !rx_hit && !req.wr)
        |=> packet_fifo_inject_ctrl[INJ_RX_BIT])
        else $error("rx arm lost before a packet start");
    a_tx_mask_used: assert property (
        @(posedge clock) disable iff (!arst_n)
        tx_hit |=> tx_flip == $past(mask_tx_reg))
        else $error("tx flip differs from mask");
    a_rx_mask_used: assert property (
        @(posedge clock) disable iff (!arst_n)
        rx_hit |=> rx_flip == $past(mask_rx_reg))
        else $error("rx flip differs from mask");
    a_pcs_now: assert property (
        @(posedge clock) disable iff (!arst_n)
        pcs_hit |=> pcs_flip == $past(mask_pcs_reg) && !pcs_fifo_inject_ctrl)
        else $error("pcs corruption not applied");
    a_pcs_span: assert property (
        @(posedge clock) disable iff (!arst_n)
        (pcs_hit ##1 pcs_wr) |=> pcs_flip == $past(mask_pcs_reg))
        else $error("pcs corruption missing on second write");
    a_pcs_end: assert property (
        @(posedge clock) disable iff (!arst_n)
        (pcs_wr && !pcs_hit && pcs_left_reg == 2'h0) |=> pcs_flip == '0)
        else $error("pcs corruption beyond its span");
    a_pcs_quiet: assert property (
        @(posedge clock) disable iff (!arst_n)
        !pcs_wr |=> pcs_flip == '0)
        else $error("pcs corruption on a skipped write");
    a_skip_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        (pcs_fifo_inject_ctrl && !pcs_wr && !req.wr) |=> pcs_fifo_inject_ctrl)
        else $error("pcs arm lost on skipped write");
    a_auto_clear: assert property (
        @(posedge clock) disable iff (!arst_n)
        (tx_hit && !req.wr) |=> !packet_fifo_inject_ctrl[INJ_TX_BIT])
        else $error("tx insertion bit not cleared");
    a_rx_auto_clear: assert property (
        @(posedge clock) disable iff (!arst_n)
        (rx_hit && !req.wr) |=> !packet_fifo_inject_ctrl[INJ_RX_BIT])
        else $error("rx insertion bit not cleared");
    a_pcs_arm_clear: assert property (
        @(posedge clock) disable iff (!arst_n)
        (pcs_hit && !req.wr) |=> !pcs_fifo_inject_ctrl)
        else $error("pcs insertion bit not cleared");

    // Observation pulses and the transmit drop counter beside them
    a_sbe_pulse: assert property (
        @(posedge clock) disable iff (!arst_n)
        (err.tx_sbe || err.rx_sbe || err.pcs_sbe) |=> ecc_sbe)
        else $error("single-bit pulse missing");
    a_mbe_pulse: assert property (
        @(posedge clock) disable iff (!arst_n)
        (err.tx_mbe || err.rx_mbe || err.pcs_mbe) |=> ecc_mbe)
        else $error("multi-bit pulse missing");
    a_drop_pulse: assert property (
        @(posedge clock) disable iff (!arst_n)
        (err.tx_drop && !cnt_rd[3] && cnt_reg[3] != CNT_MAX)
        |=> ecc_packet_dropped && cnt_reg[3] == $past(cnt_reg[3]) + 8'h01)
        else $error("drop pulse and drop count out of step");
    a_drop_pcs: assert property (
        @(posedge clock) disable iff (!arst_n)
        (!err.tx_drop && !err.rx_drop) |=> !ecc_packet_dropped)
        else $error("drop pulse without packet fifo drop");
    a_pcs_no_drop: assert property (
        @(posedge clock) disable iff (!arst_n)
        (err.pcs_mbe && !err.tx_drop && !err.rx_drop) |=> !ecc_packet_dropped)
        else $error("pcs error raised the drop pulse");

    // Masks, insertion bits and counters read as cleared at the first edge after reset
    a_reset_clean: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(arst_n) |-> (mask_tx_reg == '0 && mask_rx_reg == '0
        && mask_pcs_reg == '0 && packet_fifo_inject_ctrl == 2'h0
        && !pcs_fifo_inject_ctrl && cnt_reg[0] == CNT_RESET
        && cnt_reg[1] == CNT_RESET && cnt_reg[2] == CNT_RESET
        && cnt_reg[3] == CNT_RESET && cnt_reg[4] == CNT_RESET))
        else $error("state not cleared by reset");
endmodule
`default_nettype wire

// [test_eccs_top.sv]
/*
 * Self-checking bench for eccs_top: counters, clear on read, saturation,
 * event pulses and error injection into the packet and PCS FIFOs.
 * Assumes the plain register port with read data one cycle after rd.
 */
`timescale 1ns/100ps
`default_nettype none
module test_eccs_top;
    import eccs_pkg::*;
    localparam int          PKT_W = 32;
    localparam int          PCS_W = 32;
    localparam logic [11:0] REGS [10] = '{OFF_INJ_PKT, OFF_INJ_PCS,
        OFF_MASK_TX, OFF_MASK_RX, OFF_MASK_PCS, OFF_XAUI_MBE, OFF_TOT_SBE,
        OFF_TOT_MBE, OFF_TX_DROP, OFF_RX_DROP};
    logic                   clock;
    logic                   arst_n;
    eccs_req_s              req;
    eccs_err_s              err;
    logic [31:0]            rdata;
    logic                   tx_wr, tx_sop, rx_wr, rx_sop, pcs_wr;
    logic [PKT_W-1:0]       tx_flip, rx_flip;
    logic [PCS_W-1:0]       pcs_flip;
    logic                   ecc_sbe, ecc_mbe, ecc_packet_dropped;
    int                     miscompares;
    int                     num_checks;

    eccs_top #(.PKT_W(PKT_W), .PCS_W(PCS_W)) u_eccs_top (
        .clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .err(err),
        .tx_wr(tx_wr), .tx_sop(tx_sop), .rx_wr(rx_wr), .rx_sop(rx_sop),
        .pcs_wr(pcs_wr), .tx_flip(tx_flip), .rx_flip(rx_flip),
        .pcs_flip(pcs_flip), .ecc_sbe(ecc_sbe), .ecc_mbe(ecc_mbe),
        .ecc_packet_dropped(ecc_packet_dropped));

    // Core clock, 10 ns period
    always begin
        #5 clock = ~clock;
    end

    // Compare tasks, one per kind of result
    task automatic chk_word(string w, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_flip(string w, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_bit(string w, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask

    // Register port: one-cycle strobes, read data in the next cycle only
    task automatic wr_reg(logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clock);
        req.wr    <= 1'b0;
    endtask
    task automatic rd_chk(string w, logic [11:0] a, logic [31:0] e);
        @(posedge clock);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clock);
        req.rd   <= 1'b0;
        #1 chk_word(w, e, rdata);
    endtask
    // One-cycle error report; returns when the output pulse stands
    task automatic pulse(eccs_err_s e);
        @(posedge clock);
        err <= e;
        @(posedge clock);
        err <= '0;
        #1;
    endtask
    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
    endtask
    task automatic set_pkt(int s, logic w, logic p);
        if (s == 0) begin
            tx_wr  <= w;
            tx_sop <= p;
        end else begin
            rx_wr  <= w;
            rx_sop <= p;
        end
    endtask

    task automatic s_reset_values();
        foreach (REGS[i]) rd_chk("reset value", REGS[i], REG_RESET);
        rd_chk("unmapped", 12'h500, 32'h0000_0000);
    endtask
    task automatic s_counts();
        eccs_err_s e;
        e = '0;
        e.pcs_mbe = 1'b1;
        repeat (3) begin
            pulse(e);
            chk_bit("ecc_mbe", 1'b1, ecc_mbe);
            chk_bit("drop", 1'b0, ecc_packet_dropped);
        end
        e = '0;
        e.tx_sbe = 1'b1;
        pulse(e);
        chk_bit("ecc_sbe", 1'b1, ecc_sbe);
        e = '0;
        e.pcs_sbe = 1'b1;
        pulse(e);
        rd_chk("xaui mbe", OFF_XAUI_MBE, 32'h0000_0003);
        rd_chk("xaui mbe again", OFF_XAUI_MBE, 32'h0000_0000);
        rd_chk("total mbe", OFF_TOT_MBE, 32'h0000_0003);
        rd_chk("total sbe", OFF_TOT_SBE, 32'h0000_0002);
        rd_chk("total sbe again", OFF_TOT_SBE, 32'h0000_0000);
    endtask
    task automatic s_saturate();
        eccs_err_s e;
        e = '0;
        e.tx_drop = 1'b1;
        for (int i = 0; i < 260; i++) pulse(e);
        chk_bit("drop pulse", 1'b1, ecc_packet_dropped);
        rd_chk("tx drops", OFF_TX_DROP, 32'h0000_00ff);
        rd_chk("tx drops again", OFF_TX_DROP, 32'h0000_0000);
        e = '0;
        e.rx_drop = 1'b1;
        repeat (2) pulse(e);
        rd_chk("rx drops", OFF_RX_DROP, 32'h0000_0002);
    endtask
    // Armed while idle; a mid-packet word must pass, the next start is hit
    task automatic s_pkt_inject(int s);
        logic [31:0] m;
        m = 32'h8000_0011 << s;
        wr_reg(s ? OFF_MASK_RX : OFF_MASK_TX, m);
        wr_reg(OFF_INJ_PKT, 32'h1 << s);
        @(posedge clock);
        set_pkt(s, 1'b1, 1'b0);
        @(posedge clock);
        set_pkt(s, 1'b1, 1'b1);
        #1 chk_flip("mid word", '0, s ? rx_flip : tx_flip);
        @(posedge clock);
        set_pkt(s, 1'b0, 1'b0);
        #1 chk_flip("first word", m, s ? rx_flip : tx_flip);
        rd_chk("pkt ctrl", OFF_INJ_PKT, 32'h0000_0000);
    endtask
    // Skipped rate-match writes delay the hit; it spans two writes
    task automatic s_pcs_inject();
        wr_reg(OFF_MASK_PCS, 32'h0000_a005);
        wr_reg(OFF_INJ_PCS, 32'h0000_0001);
        repeat (3) @(posedge clock);
        pcs_wr <= 1'b1;
        #1 chk_flip("pcs skipped", '0, pcs_flip);
        @(posedge clock);
        #1 chk_flip("pcs first", 32'h0000_a005, pcs_flip);
        @(posedge clock);
        #1 chk_flip("pcs second", 32'h0000_a005, pcs_flip);
        @(posedge clock);
        pcs_wr <= 1'b0;
        #1 chk_flip("pcs third", '0, pcs_flip);
        rd_chk("pcs ctrl", OFF_INJ_PCS, 32'h0000_0000);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence; a second reset mid-run must zero everything again
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        req = '0;
        err = '0;
        {tx_wr, tx_sop, rx_wr, rx_sop, pcs_wr} = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        s_reset_values();
        s_counts();
        s_saturate();
        s_pkt_inject(0);
        s_pkt_inject(1);
        s_pcs_inject();
        wr_reg(OFF_MASK_TX, 32'hffff_ffff);
        wr_reg(OFF_INJ_PKT, 32'h0000_0003);
        pulse(eccs_err_s'(8'hff));
        do_reset();
        s_reset_values();
        final_report();
    end

    // Guard against a hang
    initial begin
        #500000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
